// ==== flash_prog_pkg.sv ====
// constants and carrier types for the flash self-program controller
`default_nettype none
package flash_prog_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int PTR_W    = 22;
	localparam int OP_W     = 21;
	localparam int WORD_W   = 16;
	localparam int WADDR_W  = 20;
	localparam int HOLD_N   = 64;
	localparam int HOLD_AW  = 6;
	localparam int WIDX_W   = 5;
	localparam int ROW_LSB  = 10;
	localparam int BLK_LSB  = 6;
	// ****************************************
	// control register fields
	// ****************************************
	localparam int BIT_FREE = 4;
	localparam int BIT_ERR  = 3;
	localparam int BIT_EN   = 2;
	localparam int BIT_WR   = 1;
	localparam logic [7:0] CTRL_MASK  = 8'h1E;
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam logic [WORD_W-1:0] NOP_WORD   = 16'h0000;
	localparam logic [WORD_W-1:0] BLANK_WORD = 16'hFFFF;
	// ****************************************
	// timing
	// ****************************************
	localparam longint CLK_PERIOD_PS = 4000;
	localparam longint PS_PER_US     = 1000000;
	localparam longint PROG_TIME_US  = 1000;
	localparam longint ERASE_TIME_US = 2000;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		SEL_CTRL, SEL_UNLOCK, SEL_LATCH, SEL_PTR_L, SEL_PTR_H, SEL_PTR_U
	} sfr_sel_t;
	typedef enum logic [1:0] {TM_KEEP, TM_POST_INC, TM_POST_DEC, TM_PRE_INC} tbl_mode_t;
	typedef struct packed {
		logic     wr;
		logic     rd;
		sfr_sel_t sel;
		logic [7:0] data;
	} sfr_req_t;
	typedef struct packed {
		logic      valid;
		logic      store;
		tbl_mode_t mode;
	} tbl_req_t;
	typedef struct packed {
		logic               we;
		logic               erase;
		logic [WADDR_W-1:0] addr;
		logic [WORD_W-1:0]  data;
	} arr_cmd_t;
endpackage
`default_nettype wire

// ==== flash_self_program_control.sv ====
// flash self-program controller: table latch, holding bytes, unlock and timed cycles
// Notes on behaviour
// - reads move one byte, programs move 64 bytes, erases clear 1024 bytes
// - the core can only request row erases, never a bulk erase
// - fetches and table accesses are refused while a cycle runs
// - an internal timer sets the length of each cycle and ends it
// - a fetched word that is not a legal opcode is handed back as a no-op
// - bytes move between array words and the core through the byte latch
// - a table store writes holding byte pointer[5:0], never the array
// - table accesses work at any byte address
// - the unlock port stores nothing and reads as zero
// - erase-select makes the next start an erase; completion clears it
// - program-enable gates every cycle and is cleared by reset
// - starting sets the fault flag; timer completion clears it
// - fault flag stays set after reset mid-cycle or an improper start
// - software can set the start bit only; hardware clears it at completion
// - control bits 7..5 and 0 read as zero
// - the byte latch is an eight-bit register
// - erase uses pointer bits 20..10 and ignores bits 9..0
// - program uses pointer bits 20..6 to pick the 64-byte block
// - table ops keep, post-inc, post-dec or pre-inc the low 21 pointer bits
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control
	import flash_prog_pkg::*;
#(
	parameter longint PROG_CYCLES  = (PROG_TIME_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
	parameter longint ERASE_CYCLES = (ERASE_TIME_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
	parameter int     TMR_W        = 24
)(
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	// special register access
	input  wire sfr_req_t           sfr_req,
	output logic [7:0]              sfr_rdata,
	// table operations
	input  wire tbl_req_t           tbl_req,
	// instruction fetch
	input  wire logic               fetch_req,
	input  wire logic [OP_W-1:0]    fetch_addr,
	output logic                    fetch_valid,
	output logic [WORD_W-1:0]       fetch_word,
	output logic                    fetch_stall,
	// flash array
	output logic [WADDR_W-1:0]      arr_raddr,
	input  wire logic [WORD_W-1:0]  arr_rdata,
	output arr_cmd_t                arr_cmd
);

	typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} unlock_t;

	localparam logic [TMR_W-1:0] PROG_LOAD  = TMR_W'(PROG_CYCLES);
	localparam logic [TMR_W-1:0] ERASE_LOAD = TMR_W'(ERASE_CYCLES);
	localparam logic [TMR_W-1:0] TMR_LAST   = TMR_W'(1);
	localparam logic [WIDX_W-1:0] WIDX_LAST = WIDX_W'(HOLD_N / 2 - 1);

	// ****************************************
	// state
	// ****************************************
	logic [PTR_W-1:0]   ptr_r;
	logic [7:0]         latch_r;
	logic [7:0]         hold_r [HOLD_N];
	logic               free_r;
	logic               err_r;
	logic               en_r;
	logic               wr_r;
	logic               erase_op_r;
	logic [TMR_W-1:0]   tmr_r;
	logic               beat_r;
	logic [WIDX_W-1:0]  widx_r;
	unlock_t            ul_r;
	logic [7:0]         rdata_r;
	logic               pend_fetch_r;
	logic               pend_tbl_r;
	logic               pend_byte_r;
	logic               fvalid_r;
	logic [WORD_W-1:0]  fword_r;
	logic [WADDR_W-1:0] raddr_r;
	arr_cmd_t           cmd_r;

	// ****************************************
	// decode
	// ****************************************
	logic             ctrl_wr;
	logic             start_req;
	logic             start_ok;
	logic             done;
	logic             tbl_go;
	logic [PTR_W-1:0] eff_ptr;

	function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p, input logic up);
		logic [OP_W-1:0] low;
		low = up ? p[OP_W-1:0] + OP_W'(1) : p[OP_W-1:0] - OP_W'(1);
		return {p[PTR_W-1:OP_W], low};
	endfunction

	function automatic logic legal_op(input logic [WORD_W-1:0] w);
		return w != BLANK_WORD;
	endfunction

	// control writes and table requests are refused while a cycle runs
	assign ctrl_wr   = sfr_req.wr && sfr_req.sel == SEL_CTRL && !wr_r;
	assign start_req = ctrl_wr && sfr_req.data[BIT_WR];
	assign start_ok  = start_req && ul_r == UL_ARMED && en_r;
	assign done      = wr_r && tmr_r == TMR_LAST;
	assign tbl_go    = tbl_req.valid && !wr_r;
	assign eff_ptr   = tbl_req.mode == TM_PRE_INC ? step_ptr(ptr_r, 1'b1) : ptr_r;

	// ****************************************
	// unlock sequence
	// ****************************************
	// the port itself keeps nothing; only the sequence position is tracked
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ul_r <= UL_IDLE;
		end else if (sfr_req.wr) begin
			unique case (ul_r)
				UL_IDLE: begin
					ul_r <= (sfr_req.sel == SEL_UNLOCK && sfr_req.data == KEY_FIRST) ? UL_KEY1 : UL_IDLE;
				end
				UL_KEY1: begin
					ul_r <= (sfr_req.sel == SEL_UNLOCK && sfr_req.data == KEY_SECOND) ? UL_ARMED : UL_IDLE;
				end
				UL_ARMED: begin
					ul_r <= UL_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			free_r <= 1'b0;
			en_r   <= 1'b0;
			wr_r   <= 1'b0;
		end else if (done) begin
			wr_r <= 1'b0;
			if (erase_op_r) begin
				free_r <= 1'b0;
			end
		end else if (ctrl_wr) begin
			free_r <= sfr_req.data[BIT_FREE];
			en_r   <= sfr_req.data[BIT_EN];
			if (start_ok) begin
				wr_r <= 1'b1;
			end
		end
	end

	// fault flag keeps its value through reset unless a cycle was cut short
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			err_r <= wr_r ? 1'b1 : err_r;
		end else if (done) begin
			err_r <= 1'b0;
		end else if (start_req) begin
			err_r <= 1'b1;
		end else if (ctrl_wr) begin
			err_r <= sfr_req.data[BIT_ERR];
		end
	end

	// ****************************************
	// programming timer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tmr_r      <= '0;
			erase_op_r <= 1'b0;
		end else if (start_ok) begin
			// only a row erase exists; nothing here can reach a bulk erase
			erase_op_r <= free_r;
			tmr_r      <= free_r ? ERASE_LOAD : PROG_LOAD;
		end else if (wr_r) begin
			tmr_r <= tmr_r - TMR_W'(1);
		end
	end

	// ****************************************
	// array commands
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			beat_r <= 1'b0;
			widx_r <= '0;
			cmd_r  <= '0;
		end else begin
			cmd_r.we    <= 1'b0;
			cmd_r.erase <= 1'b0;
			if (start_ok && free_r) begin
				cmd_r.erase <= 1'b1;
				cmd_r.addr  <= {ptr_r[OP_W-1:ROW_LSB], (ROW_LSB-1)'(0)};
			end else if (start_ok) begin
				beat_r <= 1'b1;
				widx_r <= '0;
			end
			if (beat_r) begin
				// one word per cycle, well inside the timed cycle
				cmd_r.we   <= 1'b1;
				cmd_r.addr <= {ptr_r[OP_W-1:BLK_LSB], widx_r};
				cmd_r.data <= {hold_r[{widx_r, 1'b1}], hold_r[{widx_r, 1'b0}]};
				widx_r     <= widx_r + WIDX_W'(1);
				beat_r     <= widx_r != WIDX_LAST;
			end
		end
	end

	// ****************************************
	// table pointer, latch and holding bytes
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ptr_r <= '0;
		end else if (tbl_go) begin
			unique case (tbl_req.mode)
				TM_KEEP:     ptr_r <= ptr_r;
				TM_POST_INC: ptr_r <= step_ptr(ptr_r, 1'b1);
				TM_POST_DEC: ptr_r <= step_ptr(ptr_r, 1'b0);
				TM_PRE_INC:  ptr_r <= eff_ptr;
			endcase
		end else if (sfr_req.wr && sfr_req.sel == SEL_PTR_L) begin
			ptr_r[7:0] <= sfr_req.data;
		end else if (sfr_req.wr && sfr_req.sel == SEL_PTR_H) begin
			ptr_r[15:8] <= sfr_req.data;
		end else if (sfr_req.wr && sfr_req.sel == SEL_PTR_U) begin
			ptr_r[PTR_W-1:16] <= sfr_req.data[PTR_W-17:0];
		end
	end

	// a store only fills a holding byte; the array is untouched until start
	always_ff @(posedge core_clk) begin
		if (tbl_go && tbl_req.store) begin
			hold_r[eff_ptr[HOLD_AW-1:0]] <= latch_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			latch_r <= ZERO_BYTE;
		end else if (pend_tbl_r) begin
			latch_r <= pend_byte_r ? arr_rdata[15:8] : arr_rdata[7:0];
		end else if (sfr_req.wr && sfr_req.sel == SEL_LATCH) begin
			latch_r <= sfr_req.data;
		end
	end

	// ****************************************
	// array reads for fetch and table fetch
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pend_fetch_r <= 1'b0;
			pend_tbl_r   <= 1'b0;
			pend_byte_r  <= 1'b0;
			raddr_r      <= '0;
		end else begin
			pend_tbl_r   <= tbl_go && !tbl_req.store;
			pend_fetch_r <= fetch_req && !wr_r && !tbl_go;
			if (tbl_go && !tbl_req.store) begin
				raddr_r     <= eff_ptr[OP_W-1:1];
				pend_byte_r <= eff_ptr[0];
			end else if (fetch_req && !wr_r) begin
				raddr_r <= fetch_addr[OP_W-1:1];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			fvalid_r <= 1'b0;
			fword_r  <= NOP_WORD;
		end else begin
			fvalid_r <= pend_fetch_r;
			if (pend_fetch_r) begin
				fword_r <= legal_op(arr_rdata) ? arr_rdata : NOP_WORD;
			end
		end
	end

	// ****************************************
	// register read-back
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rdata_r <= ZERO_BYTE;
		end else if (sfr_req.rd) begin
			unique case (sfr_req.sel)
				SEL_CTRL:   rdata_r <= {3'b000, free_r, err_r, en_r, wr_r, 1'b0};
				SEL_UNLOCK: rdata_r <= ZERO_BYTE;
				SEL_LATCH:  rdata_r <= latch_r;
				SEL_PTR_L:  rdata_r <= ptr_r[7:0];
				SEL_PTR_H:  rdata_r <= ptr_r[15:8];
				SEL_PTR_U:  rdata_r <= {2'b00, ptr_r[PTR_W-1:16]};
				default:    rdata_r <= ZERO_BYTE;
			endcase
		end
	end

	assign sfr_rdata   = rdata_r;
	assign fetch_valid = fvalid_r;
	assign fetch_word  = fword_r;
	assign fetch_stall = wr_r;
	assign arr_raddr   = raddr_r;
	assign arr_cmd     = cmd_r;

	// ****************************************
	// checks
	// ****************************************
	start_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(wr_r) |-> $past(ul_r) == UL_ARMED && $past(en_r))
		else $error("cycle began without unlock or enable");
	fault_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		start_req |=> err_r)
		else $error("fault flag not set by start");
	timer_end_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		done |=> !wr_r && !err_r && !fetch_stall)
		else $error("cycle did not end cleanly on timer expiry");
	start_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_r && tmr_r != TMR_LAST |=> wr_r)
		else $error("start bit dropped before timer expiry");
	fetch_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		fetch_stall && $past(fetch_stall) |-> !fetch_valid)
		else $error("fetch answered during cycle");
	erase_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		done && erase_op_r |=> !free_r)
		else $error("erase-select not cleared");
	unlock_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.sel == SEL_UNLOCK |=> sfr_rdata == ZERO_BYTE)
		else $error("unlock port read nonzero");
	ctrl_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.sel == SEL_CTRL |=> (sfr_rdata & ~CTRL_MASK) == ZERO_BYTE)
		else $error("reserved control bits nonzero");
	array_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		arr_cmd.we |-> $past(wr_r) && fetch_stall)
		else $error("array written outside a cycle");
	erase_row_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		arr_cmd.erase |-> arr_cmd.addr[ROW_LSB-2:0] == '0 && fetch_stall)
		else $error("erase address not row aligned");

endmodule
`default_nettype wire

// ==== flash_array_model.sv ====
// behavioural flash array behind the controller, small address window
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
	import flash_prog_pkg::*;
(
	// clock
	input  wire logic               core_clk,
	// array port
	input  wire logic [WADDR_W-1:0] arr_raddr,
	output logic [WORD_W-1:0]       arr_rdata,
	input  wire arr_cmd_t           arr_cmd
);
	logic [WORD_W-1:0] mem [0:2047];
	int                writes;
	initial begin
		writes = 0;
		for (int i = 0; i < 2048; i++)
			mem[i] = BLANK_WORD;
	end
	// window only: upper bits alias, so tests stay below word 2048
	assign arr_rdata = mem[arr_raddr[10:0]];
	always @(posedge core_clk) begin
		if (arr_cmd.we) begin
			mem[arr_cmd.addr[10:0]] <= arr_cmd.data;
			writes <= writes + 1;
		end
		if (arr_cmd.erase)
			for (int i = 0; i < 512; i++)
				mem[{arr_cmd.addr[10:9], 9'(i)}] <= BLANK_WORD;
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the flash self-program controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import flash_prog_pkg::*;
;
	localparam longint PC = 40;
	localparam longint EC = 50;
	logic              core_clk = 1'b0;
	logic              rst_b = 1'b0;
	sfr_req_t          sfr_req = '0;
	tbl_req_t          tbl_req = '0;
	logic              fetch_req = 1'b0;
	logic [OP_W-1:0]   fetch_addr = '0;
	logic [7:0]        sfr_rdata;
	logic              fetch_valid;
	logic              fetch_stall;
	logic [WORD_W-1:0] fetch_word;
	logic [WORD_W-1:0] arr_rdata;
	logic [WADDR_W-1:0] arr_raddr;
	arr_cmd_t          arr_cmd;
	int                fails = 0;
	int                num_checks = 0;
	int                cyc = 0;
	logic [7:0]        rd_b;
	always #2 core_clk = ~core_clk;
	flash_self_program_control #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) flash_self_program_control_i (
		.core_clk(core_clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .tbl_req(tbl_req),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
		.fetch_stall(fetch_stall), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_cmd(arr_cmd));
	flash_array_model flash_array_model_i (
		.core_clk(core_clk), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_cmd(arr_cmd));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// idle cycle after each write keeps one assignment per time step
	task automatic wr(input sfr_sel_t s, input logic [7:0] d);
		sfr_req = '{1'b1, 1'b0, s, d};
		@(negedge core_clk);
		sfr_req = '0;
		@(negedge core_clk);
	endtask
	task automatic rd(input sfr_sel_t s);
		sfr_req = '{1'b0, 1'b1, s, 8'h00};
		@(negedge core_clk);
		sfr_req = '0;
		@(negedge core_clk);
		rd_b = sfr_rdata;
	endtask
	task automatic tbl(input logic st, input tbl_mode_t m);
		tbl_req = '{1'b1, st, m};
		@(negedge core_clk);
		tbl_req = '0;
		@(negedge core_clk);
	endtask
	task automatic setp(input logic [21:0] p);
		wr(SEL_PTR_U, {2'b00, p[21:16]});
		wr(SEL_PTR_H, p[15:8]);
		wr(SEL_PTR_L, p[7:0]);
	endtask
	task automatic go(input logic [7:0] v);
		wr(SEL_CTRL, v);
		wr(SEL_UNLOCK, KEY_FIRST);
		wr(SEL_UNLOCK, KEY_SECOND);
		wr(SEL_CTRL, v | 8'h02);
	endtask
	task automatic run_len(output int n);
		n = 0;
		while (fetch_stall === 1'b1 && n < 1000) begin
			n++;
			@(negedge core_clk);
		end
	endtask
	task automatic do_fetch(input logic [OP_W-1:0] a, input logic [WORD_W-1:0] w);
		fetch_addr = a;
		fetch_req = 1'b1;
		@(negedge core_clk);
		fetch_req = 1'b0;
		@(negedge core_clk);
		chk("fetch_valid", fetch_valid, 1);
		chk("fetch_word", fetch_word, w);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rd(SEL_CTRL);
		chk("ctrl_en", rd_b & 8'hF7, 0);
		chk("ctrl_rsvd", rd_b & 8'hE1, 0);
		wr(SEL_UNLOCK, KEY_FIRST);
		rd(SEL_UNLOCK);
		chk("unlock_rd", rd_b, 0);
		wr(SEL_LATCH, 8'hA5);
		rd(SEL_LATCH);
		chk("latch", rd_b, 8'hA5);
	endtask
	task automatic t_program;
		int n;
		setp(22'h000040);
		for (int i = 0; i < 64; i++) begin
			wr(SEL_LATCH, 8'(i) ^ 8'h5A);
			tbl(1'b1, TM_POST_INC);
		end
		rd(SEL_PTR_L);
		chk("ptr_after_stores", rd_b, 8'h80);
		chk("array_untouched", flash_array_model_i.mem[32], BLANK_WORD);
		// low six bits must not move the target block
		wr(SEL_PTR_L, 8'h45);
		go(8'h04);
		chk("stall_up", fetch_stall, 1);
		wr(SEL_CTRL, 8'h04);
		rd(SEL_CTRL);
		chk("busy_flags", rd_b & 8'h0A, 8'h0A);
		fetch_req = 1'b1;
		@(negedge core_clk);
		fetch_req = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("fetch_blocked", fetch_valid, 0);
		run_len(n);
		// go, the refused write, the read and the fetch already used eight stall cycles
		chk("prog_len", n, PC - 8);
		rd(SEL_CTRL);
		chk("done_flags", rd_b & 8'h0A, 0);
		for (int k = 0; k < 32; k++)
			chk("word", flash_array_model_i.mem[32 + k], {8'(2 * k + 1) ^ 8'h5A, 8'(2 * k) ^ 8'h5A});
		chk("word_writes", flash_array_model_i.writes, 32);
	endtask
	task automatic t_tfetch;
		tbl_mode_t  m [4] = '{TM_KEEP, TM_POST_DEC, TM_PRE_INC, TM_POST_INC};
		logic [7:0] p [4] = '{8'h41, 8'h40, 8'h41, 8'h42};
		setp(22'h000041);
		for (int i = 0; i < 4; i++) begin
			tbl(1'b0, m[i]);
			rd(SEL_LATCH);
			chk("fetched_byte", rd_b, 8'h5B);
			rd(SEL_PTR_L);
			chk("ptr_mode", rd_b, p[i]);
		end
		do_fetch(21'h000040, 16'h5B5A);
	endtask
	task automatic t_erase;
		int n;
		setp(22'h0003FF);
		go(8'h14);
		run_len(n);
		// go returns one cycle into the stall
		chk("erase_len", n, EC - 1);
		rd(SEL_CTRL);
		chk("erase_flags", rd_b & 8'h1A, 0);
		chk("row_blank", flash_array_model_i.mem[32], BLANK_WORD);
		do_fetch(21'h000040, NOP_WORD);
	endtask
	task automatic t_refuse;
		wr(SEL_CTRL, 8'h04);
		wr(SEL_CTRL, 8'h06);
		chk("no_unlock", fetch_stall, 0);
		rd(SEL_CTRL);
		chk("improper_err", rd_b & 8'h0A, 8'h08);
		go(8'h00);
		chk("no_enable", fetch_stall, 0);
	endtask
	task automatic t_reset_mid;
		go(8'h04);
		rst_b = 1'b0;
		@(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		chk("stall_reset", fetch_stall, 0);
		rd(SEL_CTRL);
		chk("reset_err", rd_b & 8'h0E, 8'h08);
	endtask
	// ****************************************
	// run control
	// ****************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		t_reset;
		t_program;
		t_tfetch;
		t_erase;
		t_refuse;
		t_reset_mid;
		complete_run;
	end
endmodule
`default_nettype wire
